// [inc/frame_timer_pkg.sv]
// package for the host frame timer and status block
// assumes a single 20 MHz clock and 16-bit register ports
`default_nettype none
package frame_timer_pkg;
    // ************************************************************
    // register offsets (word addresses as printed)
    // ************************************************************
    localparam logic [15:0] FRAME_PERIOD_RELOAD_ADDR = 16'hC092;
    localparam logic [15:0] FRAME_TIMER_LIVE_ADDR = 16'hC094;
    localparam logic [15:0] NEXT_FRAME_NUMBER_ADDR = 16'hC096;
    localparam logic [15:0] HOST_INTERRUPT_FLAGS_ADDR = 16'hC090;
    localparam logic [15:0] HOST_INTERRUPT_ENABLE_ADDR = 16'hC08C;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_VBUS = 15;
    localparam int BIT_ID = 14;
    localparam int BIT_FRAME = 9;
    localparam int BIT_WAKE = 6;
    localparam int BIT_CONNECT = 4;
    localparam int BIT_SE0 = 2;
    localparam int BIT_DONE = 0;
    localparam logic [15:0] FLAG_MASK_FIRST = 16'hC251;
    localparam logic [15:0] FLAG_MASK_SECOND = 16'h0251;
    localparam int COUNT_W = 14;
    localparam int FRAME_W = 11;
    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [13:0] FRAME_RELOAD_RESET = 14'h2EE0;
    localparam logic [10:0] FRAME_NUMBER_RESET = 11'h000;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_HZ = 12000000;
    // phase accumulator step for a 12 MHz tick from 20 MHz
    localparam logic [5:0] TICK_STEP = 6'(TICK_HZ / 1000000);
    localparam logic [5:0] TICK_MOD = 6'(CLK_HZ / 1000000);
endpackage
`default_nettype wire

// [design/tick_divider.sv]
// fractional divider making a one-cycle tick enable
// assumes step below modulus, all in clk_in domain
`default_nettype none
module tick_divider (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // tick
    output logic tick_out
);
    import frame_timer_pkg::*;
    logic [5:0] acc_r;
    logic [6:0] sum;
    assign sum = {1'b0, acc_r} + {1'b0, TICK_STEP};
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            acc_r <= 6'h00;
            tick_out <= 1'b0;
        end else if (sum >= {1'b0, TICK_MOD}) begin
            acc_r <= 6'(sum - {1'b0, TICK_MOD});
            tick_out <= 1'b1;
        end else begin
            acc_r <= sum[5:0];
            tick_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [design/frame_timer_status.sv]
// host frame timer, frame number and interrupt status flags
// assumes register port synchronous to clk_in; done, wake and sof_sent_in events are one-cycle pulses, vbus, id and se0 are levels
`default_nettype none
module frame_timer_status #(
    parameter bit FIRST_INSTANCE = 1'b1
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // parallel host port access
    input wire logic hp_wr_in,
    input wire logic hp_rd_in,
    input wire logic [15:0] hp_addr_in,
    input wire logic [15:0] hp_wdata_in,
    output logic [15:0] hp_rdata_out,
    // on-chip processor access
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic [15:0] cpu_wdata_in,
    output logic [15:0] cpu_rdata_out,
    // line and engine events
    input wire logic done_event_in,
    input wire logic vbus_valid_in,
    input wire logic id_in,
    input wire logic wake_event_in,
    input wire logic port_se0_in,
    input wire logic port_active_in,
    input wire logic sof_sent_in,
    // sof request and interrupt
    output logic sof_req_out,
    output logic [10:0] sof_frame_out,
    output logic irq_out
);
    import frame_timer_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    logic tick;
    logic [COUNT_W-1:0] reload_r;
    logic [COUNT_W-1:0] count_r;
    logic [FRAME_W-1:0] frame_r;
    logic [15:0] flags_r;
    logic [15:0] enable_r;
    logic vbus_d_r, id_d_r, se0_d_r;
    logic expire;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] impl_mask;
    logic reload_wr;

    tick_divider u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tick_out(tick)
    );

    assign impl_mask = FIRST_INSTANCE ? FLAG_MASK_FIRST : FLAG_MASK_SECOND;

    function automatic logic hit(input logic stb, input logic [15:0] a, input logic [15:0] t);
        hit = stb && (a == t);
    endfunction

    assign reload_wr = hit(hp_wr_in, hp_addr_in, FRAME_PERIOD_RELOAD_ADDR)
                     | hit(cpu_wr_in, cpu_addr_in, FRAME_PERIOD_RELOAD_ADDR);

    // ************************************************************
    // frame timer
    // ************************************************************
    assign expire = tick && (count_r == '0);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            reload_r <= FRAME_RELOAD_RESET;
        end else if (hit(cpu_wr_in, cpu_addr_in, FRAME_PERIOD_RELOAD_ADDR)) begin
            reload_r <= cpu_wdata_in[COUNT_W-1:0];
        end else if (hit(hp_wr_in, hp_addr_in, FRAME_PERIOD_RELOAD_ADDR)) begin
            reload_r <= hp_wdata_in[COUNT_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_r <= FRAME_RELOAD_RESET;
        end else if (expire) begin
            count_r <= reload_r;
        end else if (tick) begin
            count_r <= count_r - 1'b1;
        end
    end

    // ************************************************************
    // frame number and sof request
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            frame_r <= FRAME_NUMBER_RESET;
        end else if (reload_wr) begin
            frame_r <= FRAME_NUMBER_RESET;
        end else if (sof_sent_in) begin
            frame_r <= frame_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sof_req_out <= 1'b0;
            sof_frame_out <= FRAME_NUMBER_RESET;
        end else begin
            sof_req_out <= expire && port_active_in;
            if (expire && port_active_in) begin
                sof_frame_out <= frame_r;
            end
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            vbus_d_r <= 1'b0;
            id_d_r <= 1'b0;
            se0_d_r <= 1'b0;
        end else begin
            vbus_d_r <= vbus_valid_in;
            id_d_r <= id_in;
            se0_d_r <= port_se0_in;
        end
    end

    always_comb begin
        set_vec = 16'h0000;
        set_vec[BIT_DONE] = done_event_in;
        set_vec[BIT_VBUS] = vbus_valid_in ^ vbus_d_r;
        set_vec[BIT_ID] = id_in ^ id_d_r;
        set_vec[BIT_FRAME] = expire;
        set_vec[BIT_WAKE] = wake_event_in;
        set_vec[BIT_CONNECT] = port_se0_in ^ se0_d_r;
        set_vec = set_vec & impl_mask;
        clr_vec = 16'h0000;
        if (hit(hp_wr_in, hp_addr_in, HOST_INTERRUPT_FLAGS_ADDR)) begin
            clr_vec = clr_vec | hp_wdata_in;
        end
        if (hit(cpu_wr_in, cpu_addr_in, HOST_INTERRUPT_FLAGS_ADDR)) begin
            clr_vec = clr_vec | cpu_wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flags_r <= 16'h0000;
        end else begin
            flags_r <= ((flags_r & ~clr_vec) | set_vec) & impl_mask;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            enable_r <= 16'h0000;
        end else if (hit(cpu_wr_in, cpu_addr_in, HOST_INTERRUPT_ENABLE_ADDR)) begin
            enable_r <= cpu_wdata_in & impl_mask;
        end else if (hit(hp_wr_in, hp_addr_in, HOST_INTERRUPT_ENABLE_ADDR)) begin
            enable_r <= hp_wdata_in & impl_mask;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(flags_r & enable_r);
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    function automatic logic [15:0] rd_mux(input logic [15:0] a);
        case (a)
            FRAME_PERIOD_RELOAD_ADDR: rd_mux = {2'b00, reload_r};
            FRAME_TIMER_LIVE_ADDR: rd_mux = {2'b00, count_r};
            NEXT_FRAME_NUMBER_ADDR: rd_mux = {5'h00, frame_r};
            HOST_INTERRUPT_FLAGS_ADDR: rd_mux = flags_r | (16'(port_se0_in) << BIT_SE0);
            HOST_INTERRUPT_ENABLE_ADDR: rd_mux = enable_r;
            default: rd_mux = 16'h0000;
        endcase
    endfunction

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hp_rdata_out <= 16'h0000;
            cpu_rdata_out <= 16'h0000;
        end else begin
            hp_rdata_out <= hp_rd_in ? rd_mux(hp_addr_in) : 16'h0000;
            cpu_rdata_out <= cpu_rd_in ? rd_mux(cpu_addr_in) : 16'h0000;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_done_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        done_event_in |=> flags_r[BIT_DONE]) else $error("done flag not set");
    chk_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (enable_r == 16'h0000) |=> !irq_out) else $error("irq while masked");
    chk_clear_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (hit(cpu_wr_in, cpu_addr_in, HOST_INTERRUPT_FLAGS_ADDR) && cpu_wdata_in[BIT_WAKE]
         && !wake_event_in && !hp_wr_in) |=> !flags_r[BIT_WAKE]) else $error("flag not cleared");
    chk_vbus_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (FIRST_INSTANCE && $changed(vbus_valid_in)) |=> flags_r[BIT_VBUS]) else $error("vbus edge lost");
    chk_second_reserved: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !FIRST_INSTANCE |-> flags_r[BIT_VBUS:BIT_ID] == 2'b00) else $error("reserved flag set");
    chk_reload_at_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        expire |=> count_r == $past(reload_r)) else $error("no reload at zero");
    chk_count_down: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tick && count_r != '0) |=> count_r == $past(count_r) - 1'b1) else $error("counter not decremented");
    chk_frame_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        reload_wr |=> frame_r == FRAME_NUMBER_RESET) else $error("frame number not cleared");
    chk_sof_request: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (expire && port_active_in) |=> sof_req_out && sof_frame_out == $past(frame_r)) else $error("sof missing");
    cov_expire: cover property (@(posedge clk_in) disable iff (!rst_n_in) expire);
    cov_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) irq_out);
    cov_sof: cover property (@(posedge clk_in) disable iff (!rst_n_in) sof_req_out ##[1:20] sof_sent_in);
    cov_flag_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(cpu_wr_in, cpu_addr_in, HOST_INTERRUPT_FLAGS_ADDR) && |(cpu_wdata_in & flags_r));
    cov_frame_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        reload_wr && frame_r != FRAME_NUMBER_RESET);

    // ************************************************************
    // flag checks
    // ************************************************************

    chk_id_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (FIRST_INSTANCE && $changed(id_in)) |=> flags_r[BIT_ID])
        else $error("id edge lost");

    chk_connect_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $changed(port_se0_in) |=> flags_r[BIT_CONNECT])
        else $error("connect edge lost");

    chk_wake_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wake_event_in |=> flags_r[BIT_WAKE])
        else $error("wake flag not set");

    chk_expire_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        expire |=> flags_r[BIT_FRAME])
        else $error("expiry flag not set");

    chk_zero_keeps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (hit(cpu_wr_in, cpu_addr_in, HOST_INTERRUPT_FLAGS_ADDR) && !cpu_wdata_in[BIT_DONE]
         && !hit(hp_wr_in, hp_addr_in, HOST_INTERRUPT_FLAGS_ADDR) && flags_r[BIT_DONE]) |=> flags_r[BIT_DONE])
        else $error("flag lost on zero write");

    chk_hp_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (hit(hp_wr_in, hp_addr_in, HOST_INTERRUPT_FLAGS_ADDR) && hp_wdata_in[BIT_WAKE]
         && !wake_event_in && !cpu_wr_in) |=> !flags_r[BIT_WAKE])
        else $error("host port clear ignored");

    // ************************************************************
    // interrupt checks
    // ************************************************************

    chk_done_irq: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (flags_r[BIT_DONE] && enable_r[BIT_DONE]) |=> irq_out)
        else $error("done irq missing");

    chk_irq_any: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (|(flags_r & enable_r)) |=> irq_out)
        else $error("enabled irq missing");

    chk_irq_none: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !(|(flags_r & enable_r)) |=> !irq_out)
        else $error("irq without enabled flag");

    // ************************************************************
    // timer and frame checks
    // ************************************************************

    chk_cpu_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(cpu_wr_in, cpu_addr_in, FRAME_PERIOD_RELOAD_ADDR) |=> reload_r == COUNT_W'($past(cpu_wdata_in)))
        else $error("reload write lost");

    chk_hp_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (hit(hp_wr_in, hp_addr_in, FRAME_PERIOD_RELOAD_ADDR) && !cpu_wr_in)
        |=> reload_r == COUNT_W'($past(hp_wdata_in)))
        else $error("host port reload lost");

    chk_frame_advance: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (sof_sent_in && !reload_wr) |=> frame_r == $past(frame_r) + 1'b1)
        else $error("frame number not advanced");

    chk_no_sof_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !(expire && port_active_in) |=> !sof_req_out)
        else $error("sof without expiry");

    // ************************************************************
    // read checks
    // ************************************************************

    chk_reload_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(cpu_rd_in, cpu_addr_in, FRAME_PERIOD_RELOAD_ADDR) |=> cpu_rdata_out == {2'b00, $past(reload_r)})
        else $error("reload readback wrong");

    chk_reload_reserved: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(hp_rd_in, hp_addr_in, FRAME_PERIOD_RELOAD_ADDR) |=> hp_rdata_out[15:COUNT_W] == 2'b00)
        else $error("reload reserved bits set");

    chk_live_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(cpu_rd_in, cpu_addr_in, FRAME_TIMER_LIVE_ADDR) |=> cpu_rdata_out == {2'b00, $past(count_r)})
        else $error("live counter readback wrong");

    chk_frame_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(cpu_rd_in, cpu_addr_in, NEXT_FRAME_NUMBER_ADDR) |=> cpu_rdata_out == {5'h00, $past(frame_r)})
        else $error("frame readback wrong");

    chk_se0_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(cpu_rd_in, cpu_addr_in, HOST_INTERRUPT_FLAGS_ADDR) |=> cpu_rdata_out[BIT_SE0] == $past(port_se0_in))
        else $error("se0 status wrong");

    chk_hp_flags_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        hit(hp_rd_in, hp_addr_in, HOST_INTERRUPT_FLAGS_ADDR) |=> (hp_rdata_out & impl_mask) == $past(flags_r))
        else $error("host port flags wrong");

    chk_idle_rdata: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !cpu_rd_in |=> cpu_rdata_out == 16'h0000)
        else $error("read data without read");
endmodule
`default_nettype wire

// [bench/usb_port_model.sv]
// model of the attached peripheral answering start-of-frame requests
// assumes sof_req_in is a one-cycle pulse in the clk_in domain
`default_nettype none
module usb_port_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // sof handshake
    input wire logic sof_req_in,
    input wire logic [3:0] delay_in,
    output logic sof_sent_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_r;
    logic busy_r;
    // sof goes out delay_in + 1 cycles after the request, prompt or slow
    always_ff @(posedge clk_in) begin
        sof_sent_out <= 1'b0;
        if (!rst_n_in) begin
            busy_r <= 1'b0;
            wait_r <= 4'h0;
        end else if (sof_req_in) begin
            busy_r <= 1'b1;
            wait_r <= delay_in;
        end else if (busy_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (busy_r) begin
            busy_r <= 1'b0;
            sof_sent_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [bench/tb_usb_host_frame_timer_status.sv]
// self-checking bench for the host frame timer and status block
// assumes frame_timer_pkg and the design files are compiled first
`default_nettype none
`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s exp %h seen %h", nm, ex, sn); end end
module tb_usb_host_frame_timer_status;
    timeunit 1ns;
    timeprecision 1ns;
    import frame_timer_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic hp_wr_in = 1'b0, hp_rd_in = 1'b0, cpu_wr_in = 1'b0, cpu_rd_in = 1'b0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rd, hp_rdata_out, cpu_rdata_out;
    logic [4:0] ev = 5'h00;
    logic port_active_in = 1'b1;
    logic sof_sent_in, sof_req_out, irq_out;
    logic [10:0] sof_frame_out;
    logic [3:0] delay = 4'h1;
    logic [4:0] evm[8] = '{5'h01, 5'h02, 5'h04, 5'h04, 5'h08, 5'h08, 5'h10, 5'h10};
    int bits[8] = '{0, 6, 15, 15, 14, 14, 4, 4};
    int bad_count = 0;
    int comparisons = 0;
    int n;
    always #25 clk_in = ~clk_in;
    frame_timer_status #(.FIRST_INSTANCE(1'b1)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .hp_wr_in(hp_wr_in), .hp_rd_in(hp_rd_in), .hp_addr_in(addr), .hp_wdata_in(wdata),
        .hp_rdata_out(hp_rdata_out),
        .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
        .cpu_rdata_out(cpu_rdata_out),
        .done_event_in(ev[0]), .wake_event_in(ev[1]), .vbus_valid_in(ev[2]), .id_in(ev[3]),
        .port_se0_in(ev[4]), .port_active_in(port_active_in), .sof_sent_in(sof_sent_in),
        .sof_req_out(sof_req_out), .sof_frame_out(sof_frame_out), .irq_out(irq_out)
    );
    // second instance: vbus and id positions stay reserved
    frame_timer_status #(.FIRST_INSTANCE(1'b0)) uut2 (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .hp_wr_in(hp_wr_in), .hp_rd_in(hp_rd_in), .hp_addr_in(addr), .hp_wdata_in(wdata),
        .hp_rdata_out(),
        .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
        .cpu_rdata_out(),
        .done_event_in(ev[0]), .wake_event_in(ev[1]), .vbus_valid_in(ev[2]), .id_in(ev[3]),
        .port_se0_in(ev[4]), .port_active_in(port_active_in), .sof_sent_in(sof_sent_in),
        .sof_req_out(), .sof_frame_out(), .irq_out()
    );
    usb_port_model peer (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sof_req_in(sof_req_out), .delay_in(delay),
        .sof_sent_out(sof_sent_in)
    );
    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic acc(input bit cpu, input bit wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        cpu_wr_in <= cpu & wr;
        cpu_rd_in <= cpu & !wr;
        hp_wr_in <= !cpu & wr;
        hp_rd_in <= !cpu & !wr;
        @(posedge clk_in);
        {cpu_wr_in, cpu_rd_in, hp_wr_in, hp_rd_in} <= 4'h0;
        #1 rd = cpu ? cpu_rdata_out : hp_rdata_out;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_sof(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_in);
            #1 cnt++;
        end while (sof_req_out !== 1'b1 && cnt < 25000);
        if (cnt >= 25000) begin
            bad_count++;
            wrap_up();
        end
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        acc(1, 0, FRAME_PERIOD_RELOAD_ADDR, 16'h0000);
        `CHK("reload rst", 16'h2EE0, rd);
        acc(0, 0, NEXT_FRAME_NUMBER_ADDR, 16'h0000);
        `CHK("frame rst", 16'h0000, rd);
        acc(0, 0, FRAME_TIMER_LIVE_ADDR, 16'h0000);
        `CHK("live rst", 1'b1, rd <= 16'h2EE0);
        acc(0, 1, FRAME_PERIOD_RELOAD_ADDR, 16'h0010); // reserved bits zero
        acc(1, 0, FRAME_PERIOD_RELOAD_ADDR, 16'h0000);
        `CHK("reload", 16'h0010, rd);
        wait_sof(n);
        wait_sof(n);
        `CHK("sof frame", 11'h001, sof_frame_out);
        `CHK("period", 1'b1, n >= 28 && n <= 29);
        acc(1, 0, FRAME_TIMER_LIVE_ADDR, 16'h0000);
        `CHK("live", 1'b1, rd <= 16'h0010);
        acc(0, 0, HOST_INTERRUPT_FLAGS_ADDR, 16'h0000);
        `CHK("expiry", 1'b1, rd[BIT_FRAME]);
        acc(1, 0, NEXT_FRAME_NUMBER_ADDR, 16'h0000);
        `CHK("frame 2", 16'h0002, rd);
        delay <= 4'hA;
        wait_sof(n);
        acc(1, 0, NEXT_FRAME_NUMBER_ADDR, 16'h0000);
        `CHK("frame held", 16'h0002, rd);
        repeat (12) @(posedge clk_in);
        acc(0, 0, NEXT_FRAME_NUMBER_ADDR, 16'h0000);
        `CHK("frame 3", 16'h0003, rd);
        acc(1, 1, FRAME_PERIOD_RELOAD_ADDR, 16'h0010);
        acc(1, 0, NEXT_FRAME_NUMBER_ADDR, 16'h0000);
        `CHK("frame clr", 16'h0000, rd);
        acc(1, 1, HOST_INTERRUPT_ENABLE_ADDR, 16'h0001);
        acc(0, 0, HOST_INTERRUPT_ENABLE_ADDR, 16'h0000);
        `CHK("enable", 16'h0001, rd);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in) ev <= ev ^ evm[i];
            if (i < 2) @(posedge clk_in) ev <= ev ^ evm[i];
            repeat (3) @(posedge clk_in);
            `CHK("irq", i == 0, irq_out);
            acc(!i[0], 1, HOST_INTERRUPT_FLAGS_ADDR, 16'h0000);
            acc(i[0], 0, HOST_INTERRUPT_FLAGS_ADDR, 16'h0000);
            `CHK("flag", 16'h0001 << bits[i], rd & 16'hC051);
            `CHK("se0", ev[4], rd[BIT_SE0]);
            acc(!i[0], 1, HOST_INTERRUPT_FLAGS_ADDR, 16'h0001 << bits[i]);
            acc(i[0], 0, HOST_INTERRUPT_FLAGS_ADDR, 16'h0000);
            `CHK("clear", 16'h0000, rd & 16'hC051);
            `CHK("irq off", 1'b0, irq_out);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
